/* File: pkg/uls_pkg.sv */
// ****************************************************************
// register map, field positions and carriers
// ****************************************************************
package uls_pkg;

    localparam int unsigned FIFO_DEPTH = 32;
    localparam int unsigned ADDR_W     = 5;

    localparam logic [4:0] OFF_LINE_STATUS  = 5'h00;
    localparam logic [4:0] OFF_MODEM_STATUS = 5'h04;
    localparam logic [4:0] OFF_EVT_STATUS   = 5'h08;
    localparam logic [4:0] OFF_EVT_MASK     = 5'h0C;

    // line_status_flags fields
    localparam int unsigned LINE_DATA_READY = 0;
    localparam int unsigned LINE_OVERRUN    = 1;
    localparam int unsigned LINE_PARITY     = 2;
    localparam int unsigned LINE_FRAMING    = 3;
    localparam int unsigned LINE_BREAK      = 4;
    localparam int unsigned LINE_FIFO_ERR   = 7;

    // modem vectors: index 0 cts, 1 dsr, 2 ri, 3 dcd
    localparam int unsigned MDM_CTS = 0;
    localparam int unsigned MDM_RI  = 2;
    localparam int unsigned MDM_DCD = 3;
    localparam int unsigned MODEM_CUR_LSB = 4;

    // event status / mask fields
    localparam int unsigned EVT_W        = 3;
    localparam int unsigned EVT_OVERRUN  = 0;
    localparam int unsigned EVT_FIFO_ERR = 1;
    localparam int unsigned EVT_MODEM    = 2;
    localparam logic [2:0]  EVT_MASK_RST = 3'h0;

    localparam int unsigned WARM_W = 3;

    typedef struct packed {
        logic done;
        logic brk;
        logic framing;
        logic parity;
    } uls_rx_evt_t;

    typedef struct packed {
        logic brk;
        logic framing;
        logic parity;
    } uls_flag_t;

    typedef struct packed {
        logic loopback;
        logic userOutputTwo;
        logic userOutputOne;
        logic rts;
        logic dtr;
    } uls_modem_ctrl_t;

    typedef struct packed {
        logic dcdN;
        logic riN;
        logic dsrN;
        logic ctsN;
    } uls_modem_pins_t;

endpackage : uls_pkg

/* File: src/uls_flag_mem.sv */
`timescale 1ns/1ns
// ****************************************************************
// per-character error flag store
// ****************************************************************
module uls_flag_mem #(
    parameter int unsigned WIDTH = 3,
    parameter int unsigned DEPTH = 32,
    parameter int unsigned AW    = 5
) (
    // clock
    input  wire logic             clk,
    // write port
    input  wire logic             wrEn,
    input  wire logic [AW-1:0]    wrAddr,
    input  wire logic [WIDTH-1:0] wrData,
    // read port, registered
    input  wire logic [AW-1:0]    rdAddr,
    output logic      [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        // bypass so a write into an empty queue shows at the head at once
        if (wrEn && (wrAddr == rdAddr)) begin
            rdData <= wrData;
        end else begin
            rdData <= mem[rdAddr];
        end
    end

endmodule : uls_flag_mem

/* File: src/uls_line_modem_status.sv */
`timescale 1ns/1ns
module uls_line_modem_status #(
    parameter int unsigned DEPTH = uls_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    sys_rst,
    // avalon-mm slave
    input  wire logic [4:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [3:0]              avs_byteenable,
    input  wire logic [31:0]             avs_writedata,
    output logic      [31:0]             avs_readdata,
    output logic                         avs_waitrequest,
    // receiver side
    input  wire uls_pkg::uls_rx_evt_t    rxEvt,
    input  wire logic                    rxDataRead,
    input  wire logic                    fifoEnable,
    output logic                         rxStore,
    output logic                         rxDataReady,
    // modem control register and flow control
    input  wire uls_pkg::uls_modem_ctrl_t modemControlBits,
    input  wire logic                    autoCtsEnable,
    output logic                         txPause,
    // modem pins, asynchronous
    input  wire uls_pkg::uls_modem_pins_t modemPins,
    // interrupts
    output logic                         modemIrq,
    output logic                         irq
);
    localparam int unsigned AW    = $clog2(DEPTH);
    localparam int unsigned CNT_W = AW + 1;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [3:0]                warmUp;
        logic [3:0]                syncA;
        logic [3:0]                syncB;
        logic [3:0]                modemCur;
        logic [3:0]                delta;
        logic [AW-1:0]             wrPtr;
        logic [AW-1:0]             rdPtr;
        logic [CNT_W-1:0]          count;
        logic                      overrun;
        logic                      fifoErr;
        logic [uls_pkg::EVT_W-1:0] evtStat;
        logic [uls_pkg::EVT_W-1:0] evtMask;
        logic                      waitReq;
        logic [31:0]               rdata;
        logic                      irq;
        logic                      modemIrq;
        logic                      txPause;
        logic                      store;
        logic                      dataReady;
    } uls_state_t;

    uls_state_t s_q;
    uls_state_t s_d;

    function automatic logic regHit(input logic [4:0] addr, input logic [4:0] off);
        regHit = (addr == off);
    endfunction : regHit

    logic               access;
    logic               readAcc;
    logic               full;
    logic               push;
    logic               pop;
    logic               ovrEvt;
    logic [3:0]         curModem;
    logic [3:0]         change;
    logic [CNT_W-1:0]   capacity;
    logic [7:0]         lineView;
    logic [7:0]         modemView;
    uls_pkg::uls_flag_t headFlags;
    uls_pkg::uls_flag_t headShown;

    // ****************************************************************
    // flag store
    // ****************************************************************
    uls_flag_mem #(
        .WIDTH ($bits(uls_pkg::uls_flag_t)),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) uls_flag_mem_inst (
        .clk    (clk),
        .wrEn   (push),
        .wrAddr (s_q.wrPtr),
        .wrData ({rxEvt.brk, rxEvt.framing, rxEvt.parity}),
        .rdAddr (s_d.rdPtr),
        .rdData (headFlags)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        access  = (avs_read || avs_write) && s_q.waitReq;
        readAcc = access && avs_read;

        // receive queue bookkeeping
        capacity = fifoEnable ? CNT_W'(DEPTH) : CNT_W'(1);
        full     = (s_q.count >= capacity);
        push     = rxEvt.done && !full;
        ovrEvt   = rxEvt.done && full;
        pop      = rxDataRead && (s_q.count != '0);
        s_d.wrPtr = s_q.wrPtr + AW'(push);
        s_d.rdPtr = s_q.rdPtr + AW'(pop);
        s_d.count = s_q.count + CNT_W'(push) - CNT_W'(pop);
        s_d.store = push;
        s_d.dataReady = (s_d.count != '0);

        // head flags only mean something while a character is held
        headShown = (s_q.count != '0) ? headFlags : '0;
        lineView  = '0;
        lineView[uls_pkg::LINE_DATA_READY] = (s_q.count != '0);
        lineView[uls_pkg::LINE_OVERRUN]    = s_q.overrun;
        lineView[uls_pkg::LINE_PARITY]     = headShown.parity;
        lineView[uls_pkg::LINE_FRAMING]    = headShown.framing;
        lineView[uls_pkg::LINE_BREAK]      = headShown.brk;
        lineView[uls_pkg::LINE_FIFO_ERR]   = s_q.fifoErr;

        // set wins over the read-clear
        s_d.overrun = (s_q.overrun && !(readAcc &&
                      regHit(avs_address, uls_pkg::OFF_LINE_STATUS))) || ovrEvt;
        s_d.fifoErr = (s_q.fifoErr && !(readAcc &&
                      regHit(avs_address, uls_pkg::OFF_LINE_STATUS))) ||
                      (push && (rxEvt.parity || rxEvt.framing || rxEvt.brk));

        // modem inputs: two flops, then loopback substitution
        s_d.syncA  = modemPins;
        s_d.syncB  = s_q.syncA;
        s_d.warmUp = {s_q.warmUp[2:0], 1'b1};
        curModem = modemControlBits.loopback ?
                   {modemControlBits.userOutputTwo, modemControlBits.userOutputOne,
                    modemControlBits.dtr, modemControlBits.rts} :
                   ~s_q.syncB;
        s_d.modemCur = curModem;
        // no change reported until the synchroniser holds real pin values
        change = s_q.warmUp[3] ? (curModem ^ s_q.modemCur) : '0;
        // ring: pin 0 to 1 is the active-high view going 1 to 0
        change[uls_pkg::MDM_RI] = s_q.warmUp[3] && s_q.modemCur[uls_pkg::MDM_RI] &&
                                  !curModem[uls_pkg::MDM_RI];
        modemView = {s_q.modemCur, s_q.delta};
        s_d.delta = ((readAcc && regHit(avs_address, uls_pkg::OFF_MODEM_STATUS)) ?
                     4'h0 : s_q.delta) | change;
        s_d.modemIrq = |s_d.delta;
        // pin high means the far end wants the transmitter held
        s_d.txPause = autoCtsEnable && s_q.syncB[uls_pkg::MDM_CTS];

        // event status, read-clear with set winning
        if (readAcc && regHit(avs_address, uls_pkg::OFF_EVT_STATUS)) begin
            s_d.evtStat = '0;
        end
        s_d.evtStat[uls_pkg::EVT_OVERRUN]  = s_d.evtStat[uls_pkg::EVT_OVERRUN] | ovrEvt;
        s_d.evtStat[uls_pkg::EVT_FIFO_ERR] = s_d.evtStat[uls_pkg::EVT_FIFO_ERR] |
                                             (s_d.fifoErr && !s_q.fifoErr);
        s_d.evtStat[uls_pkg::EVT_MODEM]    = s_d.evtStat[uls_pkg::EVT_MODEM] | (|change);
        if (access && avs_write && avs_byteenable[0] &&
            regHit(avs_address, uls_pkg::OFF_EVT_MASK)) begin
            s_d.evtMask = avs_writedata[uls_pkg::EVT_W-1:0];
        end
        s_d.irq = |(s_d.evtStat & s_d.evtMask);

        // one wait cycle: answer comes the edge after the request is taken
        s_d.waitReq = !access;
        if (readAcc) begin
            unique case (avs_address)
                uls_pkg::OFF_LINE_STATUS:  s_d.rdata = {24'h000000, lineView};
                uls_pkg::OFF_MODEM_STATUS: s_d.rdata = {24'h000000, modemView};
                uls_pkg::OFF_EVT_STATUS:   s_d.rdata = {29'h00000000, s_q.evtStat};
                uls_pkg::OFF_EVT_MASK:     s_d.rdata = {29'h00000000, s_q.evtMask};
                default:                   s_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q         <= '0;
            s_q.evtMask <= uls_pkg::EVT_MASK_RST;
            s_q.waitReq <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata    = s_q.rdata;
    assign avs_waitrequest = s_q.waitReq;
    assign rxStore         = s_q.store;
    assign rxDataReady     = s_q.dataReady;
    assign txPause         = s_q.txPause;
    assign modemIrq        = s_q.modemIrq;
    assign irq             = s_q.irq;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic modemRd;
    logic lineRd;
    assign modemRd = readAcc && regHit(avs_address, uls_pkg::OFF_MODEM_STATUS);
    assign lineRd  = readAcc && regHit(avs_address, uls_pkg::OFF_LINE_STATUS);

    sequence s_push_empty_err(bit pe, bit fe);
        rxEvt.done && (s_q.count == '0) && !rxDataRead &&
        (rxEvt.parity == pe) && (rxEvt.framing == fe);
    endsequence

    property p_head_flags;
        (rxEvt.done && (s_q.count == '0) && !rxDataRead) |=>
        (lineView[uls_pkg::LINE_PARITY] == $past(rxEvt.parity)) &&
        (lineView[uls_pkg::LINE_FRAMING] == $past(rxEvt.framing));
    endproperty
    a_head_flags: assert property (p_head_flags)
        else $error("head flags wrong");

    // a read in the first cycle may clear the flag; a fresh overrun sets it again
    property p_overrun;
        (rxEvt.done && full) |=> s_q.overrun ##1 ($past(lineRd) || s_q.overrun);
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged");

    property p_no_store_full;
        (rxEvt.done && full && !rxDataRead) |=> $stable(s_q.count) && !rxStore;
    endproperty
    a_no_store_full: assert property (p_no_store_full)
        else $error("stored on overrun");

    property p_ready;
        s_push_empty_err(1'b0, 1'b0) |=> lineView[uls_pkg::LINE_DATA_READY] && rxDataReady;
    endproperty
    a_ready: assert property (p_ready)
        else $error("data ready missing");

    sequence s_modem_move;
        // leaving loopback may jump the view without a pin move
        !modemControlBits.loopback && !$past(modemControlBits.loopback) && s_q.warmUp[3] &&
        $changed(s_q.syncB[uls_pkg::MDM_CTS]);
    endsequence

    property p_delta_set;
        s_modem_move ##1 1'b1 |-> s_q.delta[uls_pkg::MDM_CTS];
    endproperty
    a_delta_set: assert property (p_delta_set)
        else $error("change bit not set");

    property p_read_clear;
        (modemRd && !(|change)) |=> (s_q.delta == 4'h0) ##1
        (avs_readdata[3:0] == $past(s_q.delta, 2));
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("read did not clear");

    property p_loop_view;
        (modemControlBits.loopback && $stable(modemControlBits)) [*2] |->
        s_q.modemCur == {modemControlBits.userOutputTwo, modemControlBits.userOutputOne,
                         modemControlBits.dtr, modemControlBits.rts};
    endproperty
    a_loop_view: assert property (p_loop_view)
        else $error("loopback view wrong");

    property p_cts_pause;
        (autoCtsEnable && s_q.syncB[uls_pkg::MDM_CTS]) |=> txPause;
    endproperty
    a_cts_pause: assert property (p_cts_pause)
        else $error("transmitter not paused");

    property p_dcd_irq;
        $rose(s_q.delta[uls_pkg::MDM_DCD]) |-> modemIrq;
    endproperty
    a_dcd_irq: assert property (p_dcd_irq)
        else $error("dcd change without interrupt");

    property p_ri_edge;
        $rose(s_q.delta[uls_pkg::MDM_RI]) |->
        $past(s_q.modemCur[uls_pkg::MDM_RI]) && !s_q.modemCur[uls_pkg::MDM_RI];
    endproperty
    a_ri_edge: assert property (p_ri_edge)
        else $error("ring change on wrong edge");

    property p_modem_irq;
        (s_q.delta == 4'h0) && !(|change) |=> !modemIrq;
    endproperty
    a_modem_irq: assert property (p_modem_irq)
        else $error("modem interrupt stuck");

    property p_fifo_err;
        (push && rxEvt.parity) |=> s_q.fifoErr;
    endproperty
    a_fifo_err: assert property (p_fifo_err)
        else $error("queue error flag missing");

    property p_read_race;
        (modemRd && change[uls_pkg::MDM_CTS]) |=> s_q.delta[uls_pkg::MDM_CTS];
    endproperty
    a_read_race: assert property (p_read_race)
        else $error("change lost to read");

endmodule : uls_line_modem_status

/* File: dv/uls_modem_model.sv */
`timescale 1ns/1ns
// ******************
// far-side modem
// ******************
module uls_modem_model (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    // wanted pin levels and reaction time
    input  wire uls_pkg::uls_modem_pins_t reqPins,
    input  wire logic [3:0]               reqDelay,
    // active-low pins toward the uart
    output uls_pkg::uls_modem_pins_t      modemPins
);
    logic [3:0] waitCnt_q;

    // pins rest inactive high; a slow modem answers reqDelay+1 cycles after the request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            modemPins <= '1;
            waitCnt_q <= 4'h0;
        end else if (modemPins != reqPins) begin
            if (waitCnt_q >= reqDelay) begin
                modemPins <= reqPins;
                waitCnt_q <= 4'h0;
            end else begin
                waitCnt_q <= waitCnt_q + 4'h1;
            end
        end
    end
endmodule : uls_modem_model

/* File: dv/uls_line_modem_status_tb.sv */
`timescale 1ns/1ns
module uls_line_modem_status_tb;
    localparam int unsigned DEPTH = 4;
    logic                     clk = 1'b0;
    logic                     sysRst = 1'b1;
    logic [4:0]               avsAddress = 5'h00;
    logic                     avsRead = 1'b0;
    logic                     avsWrite = 1'b0;
    logic [31:0]              avsWritedata = 32'h0;
    logic [31:0]              avsReaddata;
    logic                     avsWaitrequest;
    uls_pkg::uls_rx_evt_t     rxEvt = '0;
    logic                     rxDataRead = 1'b0;
    logic                     fifoEnable = 1'b1;
    logic                     rxStore;
    logic                     rxDataReady;
    uls_pkg::uls_modem_ctrl_t modemControlBits = '0;
    logic                     autoCtsEnable = 1'b0;
    logic                     txPause;
    uls_pkg::uls_modem_pins_t modemPins;
    uls_pkg::uls_modem_pins_t reqPins = '1;
    logic [3:0]               reqDelay = 4'h0;
    logic                     modemIrq;
    logic                     irq;
    logic [31:0]              d;
    int                       failures = 0;
    int                       nTests = 0;

    always #20 clk = ~clk;

    uls_line_modem_status #(.DEPTH(DEPTH)) uls_line_modem_status_inst (
        .clk(clk), .sys_rst(sysRst), .avs_address(avsAddress), .avs_read(avsRead),
        .avs_write(avsWrite), .avs_byteenable(4'hF), .avs_writedata(avsWritedata),
        .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .rxEvt(rxEvt),
        .rxDataRead(rxDataRead), .fifoEnable(fifoEnable), .rxStore(rxStore),
        .rxDataReady(rxDataReady), .modemControlBits(modemControlBits),
        .autoCtsEnable(autoCtsEnable), .txPause(txPause), .modemPins(modemPins),
        .modemIrq(modemIrq), .irq(irq));

    uls_modem_model uls_modem_model_inst (
        .clk(clk), .sys_rst(sysRst), .reqPins(reqPins), .reqDelay(reqDelay),
        .modemPins(modemPins));

    // ******************
    // shared tasks
    // ******************
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    task check(input logic [31:0] seen, input logic [31:0] exp);
        nTests++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // holds the request until waitrequest is sampled low
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk);
        avsAddress <= a;
        avsRead <= ~wr;
        avsWrite <= wr;
        avsWritedata <= wd;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (avsWaitrequest === 1'b0) break;
        end
        if (i == 20) begin
            failures++;
            tally_and_finish();
        end
        d = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask : bus

    task rx_push(input int n, input logic [2:0] f);
        @(posedge clk);
        rxEvt <= {1'b1, f};
        repeat (n) @(posedge clk);
        rxEvt <= '0;
        repeat (3) @(posedge clk);
    endtask : rx_push

    task pop;
        @(posedge clk);
        rxDataRead <= 1'b1;
        @(posedge clk);
        rxDataRead <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pop

    // ******************
    // scenarios
    // ******************
    task t_reset;
        check({irq, modemIrq, txPause, rxDataReady}, 32'h0);
        bus(1'b0, uls_pkg::OFF_LINE_STATUS, 32'h0); check(d, 32'h00);
        bus(1'b0, uls_pkg::OFF_MODEM_STATUS, 32'h0); check(d, 32'h00);
        bus(1'b0, uls_pkg::OFF_EVT_MASK, 32'h0); check(d, 32'h00);
        bus(1'b0, 5'h10, 32'h0); check(d, 32'h00);
        $display("test reset done");
    endtask : t_reset

    task t_rx_flags;
        rx_push(1, 3'b001);
        rx_push(1, 3'b010);
        rx_push(1, 3'b100);
        check(rxDataReady, 32'h1);
        bus(1'b0, uls_pkg::OFF_LINE_STATUS, 32'h0); check(d, 32'h85);
        bus(1'b0, uls_pkg::OFF_LINE_STATUS, 32'h0); check(d, 32'h05);
        pop();
        bus(1'b0, uls_pkg::OFF_LINE_STATUS, 32'h0); check(d, 32'h09);
        pop();
        bus(1'b0, uls_pkg::OFF_LINE_STATUS, 32'h0); check(d, 32'h11);
        pop();
        bus(1'b0, uls_pkg::OFF_LINE_STATUS, 32'h0); check(d, 32'h00);
        check(rxDataReady, 32'h0);
        bus(1'b0, uls_pkg::OFF_EVT_STATUS, 32'h0); check(d, 32'h02);
        $display("test receive flags done");
    endtask : t_rx_flags

    task t_overrun;
        rx_push(DEPTH, 3'b000);
        rx_push(1, 3'b001);
        check(irq, 32'h0);
        bus(1'b1, uls_pkg::OFF_EVT_MASK, 32'h1);
        repeat (2) @(posedge clk);
        check(irq, 32'h1);
        bus(1'b0, uls_pkg::OFF_LINE_STATUS, 32'h0); check(d, 32'h03);
        // the refused parity character must never reach the head
        for (int k = 0; k < DEPTH; k++) begin
            bus(1'b0, uls_pkg::OFF_LINE_STATUS, 32'h0); check(d, 32'h01);
            pop();
        end
        bus(1'b0, uls_pkg::OFF_LINE_STATUS, 32'h0); check(d, 32'h00);
        bus(1'b0, uls_pkg::OFF_EVT_STATUS, 32'h0); check(d, 32'h01);
        repeat (2) @(posedge clk);
        check(irq, 32'h0);
        $display("test overrun done");
    endtask : t_overrun

    task t_modem;
        logic [3:0] chg;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            reqPins[i] <= 1'b0;
            reqDelay <= (i == 2) ? 4'h5 : 4'h0;
            repeat (14) @(posedge clk);
            chg = (i == uls_pkg::MDM_RI) ? 4'h0 : 4'(1 << i);
            check(modemIrq, 32'(chg != 4'h0));
            bus(1'b0, uls_pkg::OFF_MODEM_STATUS, 32'h0);
            check(d, {24'h0, ~reqPins, chg});
            bus(1'b0, uls_pkg::OFF_MODEM_STATUS, 32'h0);
            check(d, {24'h0, ~reqPins, 4'h0});
        end
        // clear the modem event left by the loop so the interrupt below is fresh
        bus(1'b0, uls_pkg::OFF_EVT_STATUS, 32'h0); check(d, 32'h04);
        bus(1'b1, uls_pkg::OFF_EVT_MASK, 32'h4);
        check(irq, 32'h0);
        reqPins <= '1;
        repeat (14) @(posedge clk);
        check(irq, 32'h1);
        bus(1'b0, uls_pkg::OFF_MODEM_STATUS, 32'h0); check(d, 32'h0F);
        bus(1'b0, uls_pkg::OFF_EVT_STATUS, 32'h0); check(d, 32'h04);
        repeat (2) @(posedge clk);
        check({irq, modemIrq}, 32'h0);
        $display("test modem changes done");
    endtask : t_modem

    task t_loopback;
        static logic [7:0] expHi [5] = '{8'h20, 8'h10, 8'h40, 8'h80, 8'h00};
        @(posedge clk);
        reqPins <= '0;
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            modemControlBits <= {1'b1, 4'(1 << k)};
            repeat (14) @(posedge clk);
            bus(1'b0, uls_pkg::OFF_MODEM_STATUS, 32'h0);
            check(d & 32'hF0, {24'h0, expHi[k]});
        end
        modemControlBits <= '0;
        repeat (4) @(posedge clk);
        bus(1'b0, uls_pkg::OFF_MODEM_STATUS, 32'h0); check(d & 32'hF0, 32'hF0);
        $display("test loopback done");
    endtask : t_loopback

    task t_cts;
        autoCtsEnable <= 1'b1;
        repeat (3) @(posedge clk);
        check(txPause, 32'h0);
        bus(1'b0, uls_pkg::OFF_MODEM_STATUS, 32'h0);
        reqPins <= '1;
        // read taken in the very cycle the pin change reaches the compare
        repeat (2) @(posedge clk);
        bus(1'b0, uls_pkg::OFF_MODEM_STATUS, 32'h0); check(d, 32'hF0);
        bus(1'b0, uls_pkg::OFF_MODEM_STATUS, 32'h0); check(d, 32'h0F);
        check(txPause, 32'h1);
        autoCtsEnable <= 1'b0;
        repeat (3) @(posedge clk);
        check(txPause, 32'h0);
        $display("test flow pause done");
    endtask : t_cts

    // single holding register: second character overruns, first stays at the head
    task t_holding;
        fifoEnable <= 1'b0;
        @(posedge clk);
        rxEvt <= 4'h8;
        @(posedge clk);
        rxEvt <= 4'h9;
        @(posedge clk);
        rxEvt <= '0;
        check(rxStore, 32'h1);
        @(posedge clk);
        check(rxStore, 32'h0);
        repeat (2) @(posedge clk);
        bus(1'b0, uls_pkg::OFF_LINE_STATUS, 32'h0); check(d, 32'h03);
        pop();
        bus(1'b0, uls_pkg::OFF_LINE_STATUS, 32'h0); check(d, 32'h00);
        fifoEnable <= 1'b1;
        $display("test holding register done");
    endtask : t_holding

    initial begin
        repeat (12) @(posedge clk);
        sysRst <= 1'b0;
        repeat (6) @(posedge clk);
        t_reset();
        t_rx_flags();
        t_overrun();
        t_modem();
        t_loopback();
        t_cts();
        t_holding();
        tally_and_finish();
    end
endmodule : uls_line_modem_status_tb
